// file: rtl/ctic_pkg.sv
package ctic_pkg;
	// ==========================================
	// register map (printed index, byte = 4*index)
	localparam logic [7:0] TCC_INDEX = 8'h05;
	localparam logic [7:0] IWW_INDEX = 8'h07;
	localparam logic [7:0] WDC_INDEX = 8'h08;
	localparam logic [7:0] CAPV_INDEX = 8'h09;
	localparam logic [7:0] TCC_ADDR = 8'h14;
	localparam logic [7:0] IWW_ADDR = 8'h1C;
	localparam logic [7:0] WDC_ADDR = 8'h20;
	localparam logic [7:0] CAPV_ADDR = 8'h24;
	// ==========================================
	// timer_capture_control fields
	localparam int RISE_BIT = 15;
	localparam int FALL_BIT = 14;
	localparam int PER_TO_BIT = 13;
	localparam int CAP_TO_BIT = 12;
	localparam int PER_SEL_LSB = 8;
	localparam int SRC_SEL_BIT = 7;
	localparam int HOLD_BIT = 6;
	localparam int EDGE_LSB = 4;
	localparam int FILT_LSB = 2;
	localparam int DIV_LSB = 0;
	localparam logic [11:0] TCC_RESET = 12'h000;
	// ==========================================
	// interrupt_watchdog_wake_control fields
	localparam int PRIO_LSB = 13;
	localparam int MASK_LSB = 10;
	localparam int WDT_SEL_LSB = 8;
	localparam int SMR_FLAG_BIT = 7;
	localparam int SMR_POL_BIT = 6;
	localparam int WAKE_LSB = 0;
	localparam logic [15:0] IWW_RESET = 16'h0000;
	// watchdog control fields
	localparam int WDC_EN_BIT = 0;
	localparam int WDC_SLOW_BIT = 1;
	// ==========================================
	// timing
	localparam int CLK_NS = 40;
	localparam int PER_BASE_NS = 15625000;
	localparam int WDT0_NS = 1830000;
	localparam int WDT1_NS = 7680000;
	localparam int WDT2_NS = 31120000;
	localparam int WDT3_NS = 124800000;
	localparam int PER_BASE_CYC = PER_BASE_NS / CLK_NS;
	localparam int WDT0_CYC = WDT0_NS / CLK_NS;
	localparam int WDT1_CYC = WDT1_NS / CLK_NS;
	localparam int WDT2_CYC = WDT2_NS / CLK_NS;
	localparam int WDT3_CYC = WDT3_NS / CLK_NS;
	localparam int FILT_CYC1 = 8;
	localparam int FILT_CYC2 = 32;
	localparam int FILT_CYC3 = 128;
endpackage

// file: rtl/ctic_timer_irq.sv
`timescale 1ns/100ps
// Function
// - rise flag set on capture, write-1 clears
// - fall flag set on capture, write-1 clears
// - periodic timeout flag, write-1 clears
// - capture timeout flag, write-1 clears
// - period field picks 1s to 15.625ms
// - select bit routes periodic or capture
// - hold bit stops capture counter
// - edge field picks none/rise/fall/both
// - filter rejects pulses under 8/32/128
// - capture clock divides by 4..32
// - mask bits gate each core input
// - watchdog period field picks four timeouts
// - stop recovered flag read only
// - wake combine OR or NAND
// - six wake pin enable bits
// - core inputs keep fixed priority
// - priority field routes sync and timer
// - codes 010/011 merge syncs on zero
// - watchdog off after reset, fast only
module ctic_timer_irq #(
	parameter int PER_BASE_CYCLES = ctic_pkg::PER_BASE_CYC,
	parameter int WDT0_CYCLES = ctic_pkg::WDT0_CYC,
	parameter int WDT1_CYCLES = ctic_pkg::WDT1_CYC,
	parameter int WDT2_CYCLES = ctic_pkg::WDT2_CYC,
	parameter int WDT3_CYCLES = ctic_pkg::WDT3_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic capture_in,
	input wire logic hsync_in,
	input wire logic vsync_in,
	input wire logic stop_recovered_in,
	input wire logic [5:0] wake_pins,
	output logic wake_request,
	output logic watchdog_reset,
	output logic core_irq_zero,
	output logic core_irq_one,
	output logic core_irq_two
);
	import ctic_pkg::*;

	// ==========================================
	// input synchronisers
	logic [9:0] sync1_ff;
	logic [9:0] sync2_ff;
	logic cap_s, hs_s, vs_s, smr_s;
	logic [5:0] wake_s;

	// two stages for every outside pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= 10'h000;
			sync2_ff <= 10'h000;
		end else begin
			sync1_ff <= {wake_pins, stop_recovered_in, vsync_in, hsync_in, capture_in};
			sync2_ff <= sync1_ff;
		end
	end
	assign cap_s = sync2_ff[0];
	assign hs_s = sync2_ff[1];
	assign vs_s = sync2_ff[2];
	assign smr_s = sync2_ff[3];
	assign wake_s = sync2_ff[9:4];

	// ==========================================
	// registers
	logic [11:0] tcc_ff;
	logic [3:0] flags_ff;
	// bit 7 is never stored: the stop flag reads live from its pin
	logic [15:0] iww_ff;
	logic [1:0] wdc_ff;
	logic [15:0] capv_ff;
	logic [3:0] nxt_flags;
	logic [3:0] flag_set;
	logic [3:0] flag_clr;

	// apb decode
	wire setup = psel && !penable;
	wire wr_go = psel && penable && pwrite && pready;
	wire hit_tcc = paddr == TCC_ADDR;
	wire hit_iww = paddr == IWW_ADDR;
	wire hit_wdc = paddr == WDC_ADDR;
	wire hit_capv = paddr == CAPV_ADDR;
	wire mapped = hit_tcc || hit_iww || hit_wdc || hit_capv;
	wire wr_tcc = wr_go && hit_tcc && !pslverr;
	wire wr_iww = wr_go && hit_iww && !pslverr;
	wire wr_wdc = wr_go && hit_wdc && !pslverr;

	// read data mux
	// reserved bits and the upper half read as zero
	wire [15:0] tcc_view = {flags_ff, 2'b00, tcc_ff[9:0]};
	wire [15:0] iww_view = {iww_ff[15:8], smr_s, iww_ff[6:0]};
	wire [31:0] rd_mux = hit_tcc ? {16'h0000, tcc_view} :
		hit_iww ? {16'h0000, iww_view} :
		hit_wdc ? {30'h00000000, wdc_ff} :
		hit_capv ? {16'h0000, capv_ff} : 32'h00000000;

	// no wait state: data and ready come from flops loaded in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped;
			if (setup) begin
				prdata <= rd_mux;
			end
		end
	end

	// control fields
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tcc_ff <= TCC_RESET;
			iww_ff <= IWW_RESET;
		end else begin
			if (wr_tcc) begin
				tcc_ff <= {2'b00, pwdata[9:0]};
			end
			if (wr_iww) begin
				iww_ff <= {pwdata[15:8], 1'b0, pwdata[6:0]};
			end
		end
	end

	wire [1:0] per_sel = tcc_ff[PER_SEL_LSB+:2];
	wire src_sel = tcc_ff[SRC_SEL_BIT];
	wire hold = tcc_ff[HOLD_BIT];
	wire [1:0] edge_sel = tcc_ff[EDGE_LSB+:2];
	wire [1:0] filt_sel = tcc_ff[FILT_LSB+:2];
	wire [1:0] div_sel = tcc_ff[DIV_LSB+:2];
	wire [2:0] prio = iww_ff[PRIO_LSB+:3];
	wire [2:0] mask = iww_ff[MASK_LSB+:3];
	wire [1:0] wdt_sel = iww_ff[WDT_SEL_LSB+:2];
	wire wake_pol = iww_ff[SMR_POL_BIT];
	wire [5:0] wake_en = iww_ff[WAKE_LSB+:6];

	// ==========================================
	// sticky flags: set wins over write-1 clear
	// bit order: rise, fall, periodic, capture timeout
	logic rise_ev, fall_ev, per_ev, capto_ev;
	assign flag_set = {rise_ev, fall_ev, per_ev, capto_ev};
	assign flag_clr = wr_tcc ? pwdata[15:12] : 4'h0;
	assign nxt_flags = flag_set | (flags_ff & ~flag_clr);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_ff <= 4'h0;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	// ==========================================
	// glitch filter on capture pin
	logic [6:0] filt_cnt_ff;
	logic filt_ff;
	logic filt_prev_ff;
	logic [6:0] filt_lim;

	// a differing level must last the whole window before it is taken
	// last count before the new level is accepted
	assign filt_lim = filt_sel == 2'b01 ? 7'(FILT_CYC1 - 1) :
		filt_sel == 2'b10 ? 7'(FILT_CYC2 - 1) : 7'(FILT_CYC3 - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filt_cnt_ff <= 7'h00;
			filt_ff <= 1'b0;
			filt_prev_ff <= 1'b0;
		end else begin
			filt_prev_ff <= filt_ff;
			if (filt_sel == 2'b00 || cap_s == filt_ff) begin
				filt_cnt_ff <= 7'h00;
				filt_ff <= cap_s;
			end else if (filt_cnt_ff == filt_lim) begin
				filt_cnt_ff <= 7'h00;
				filt_ff <= cap_s;
			end else begin
				filt_cnt_ff <= filt_cnt_ff + 7'h01;
			end
		end
	end

	wire rise_seen = filt_ff && !filt_prev_ff;
	wire fall_seen = !filt_ff && filt_prev_ff;
	assign rise_ev = rise_seen && edge_sel[0];
	assign fall_ev = fall_seen && edge_sel[1];

	// ==========================================
	// capture clock prescaler and counter
	// prescaler runs free, so hold freezes only the count
	logic [4:0] pre_ff;
	logic [15:0] cap_cnt_ff;
	logic [4:0] pre_lim;

	assign pre_lim = 5'((5'h04 << div_sel) - 5'h01);
	wire cap_tick = pre_ff == pre_lim;
	wire cap_wrap = cap_tick && !hold && cap_cnt_ff == 16'hFFFF;
	assign capto_ev = cap_wrap;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_ff <= 5'h00;
		end else if (cap_tick) begin
			pre_ff <= 5'h00;
		end else begin
			pre_ff <= pre_ff + 5'h01;
		end
	end

	// captured edges latch the count and restart it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_cnt_ff <= 16'h0000;
			capv_ff <= 16'h0000;
		end else if (rise_ev || fall_ev) begin
			capv_ff <= cap_cnt_ff;
			cap_cnt_ff <= 16'h0000;
		end else if (cap_tick && !hold) begin
			cap_cnt_ff <= cap_cnt_ff + 16'h0001;
		end
	end

	// ==========================================
	// periodic timer: base tick times 1/4/16/64
	// a count left above a new, shorter limit fires at the next base tick
	logic [31:0] base_ff;
	logic [5:0] per_cnt_ff;
	logic [5:0] per_lim;

	assign per_lim = per_sel == 2'b00 ? 6'h3F :
		per_sel == 2'b01 ? 6'h0F :
		per_sel == 2'b10 ? 6'h03 : 6'h00;
	wire base_tick = base_ff == 32'(PER_BASE_CYCLES - 1);
	assign per_ev = base_tick && per_cnt_ff >= per_lim;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_ff <= 32'h00000000;
			per_cnt_ff <= 6'h00;
		end else if (base_tick) begin
			base_ff <= 32'h00000000;
			per_cnt_ff <= per_ev ? 6'h00 : per_cnt_ff + 6'h01;
		end else begin
			base_ff <= base_ff + 32'h00000001;
		end
	end

	// ==========================================
	// interrupt routing
	logic [1:0] hs_prev_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_prev_ff <= 2'b00;
		end else begin
			hs_prev_ff <= {vs_s, hs_s};
		end
	end
	wire hs_ev = hs_s && !hs_prev_ff[0];
	wire vs_ev = vs_s && !hs_prev_ff[1];
	wire cap_src = rise_ev || fall_ev || capto_ev;
	wire tmr_ev = src_sel ? per_ev : cap_src;

	// destination input of each source per code
	function automatic logic [5:0] route(input logic [2:0] code);
		// packed as {timer, vsync, hsync} two bits each
		case (code)
			3'b001: route = {2'd1, 2'd2, 2'd0};
			3'b010: route = {2'd2, 2'd0, 2'd0};
			3'b011: route = {2'd1, 2'd0, 2'd0};
			3'b100: route = {2'd0, 2'd2, 2'd1};
			3'b101: route = {2'd0, 2'd1, 2'd2};
			default: route = {2'd2, 2'd1, 2'd0};
		endcase
	endfunction

	wire [5:0] dst = route(prio);
	logic [2:0] irq_raw;
	always_comb begin
		irq_raw = 3'b000;
		for (int i = 0; i < 3; i++) begin
			irq_raw[i] = (hs_ev && dst[1:0] == 2'(i)) ||
				(vs_ev && dst[3:2] == 2'(i)) ||
				(tmr_ev && dst[5:4] == 2'(i));
		end
	end
	// no pending state: a masked event is simply dropped
	wire [2:0] irq_gated = irq_raw & mask;

	// each core input on its own line; the core ranks them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_irq_zero <= 1'b0;
			core_irq_one <= 1'b0;
			core_irq_two <= 1'b0;
		end else begin
			core_irq_zero <= irq_gated[0];
			core_irq_one <= irq_gated[1];
			core_irq_two <= irq_gated[2];
		end
	end

	// ==========================================
	// stop recovery wake combine
	wire wake_or = |(wake_s & wake_en);
	wire wake_nand = (wake_en != 6'h00) && !(&(wake_s | ~wake_en));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_request <= 1'b0;
		end else begin
			wake_request <= wake_pol ? wake_nand : wake_or;
		end
	end

	// ==========================================
	// watchdog: off after reset, runs only in fast mode
	logic [31:0] wdt_cnt_ff;
	logic [31:0] wdt_lim;
	wire wdt_en = wdc_ff[WDC_EN_BIT];
	wire slow = wdc_ff[WDC_SLOW_BIT];
	// a start written together with the slow bit is refused
	wire wdt_kick = wr_wdc && pwdata[WDC_EN_BIT] && !pwdata[WDC_SLOW_BIT];

	assign wdt_lim = wdt_sel == 2'b00 ? 32'(WDT0_CYCLES - 1) :
		wdt_sel == 2'b01 ? 32'(WDT1_CYCLES - 1) :
		wdt_sel == 2'b10 ? 32'(WDT2_CYCLES - 1) : 32'(WDT3_CYCLES - 1);
	wire wdt_exp = wdt_en && !slow && wdt_cnt_ff >= wdt_lim;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdc_ff <= 2'b00;
		end else if (wdt_exp) begin
			wdc_ff <= {slow, 1'b0};
		end else if (wr_wdc) begin
			wdc_ff[WDC_SLOW_BIT] <= pwdata[WDC_SLOW_BIT];
			if (wdt_kick) begin
				wdc_ff[WDC_EN_BIT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_cnt_ff <= 32'h00000000;
			watchdog_reset <= 1'b0;
		end else begin
			watchdog_reset <= wdt_exp;
			if (wdt_kick || wdt_exp) begin
				wdt_cnt_ff <= 32'h00000000;
			end else if (wdt_en && !slow) begin
				wdt_cnt_ff <= wdt_cnt_ff + 32'h00000001;
			end
		end
	end

endmodule

// file: tb/ctic_timer_irq_assertions.sv
`timescale 1ns/100ps
module ctic_timer_irq_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic stop_recovered_in,
	input wire logic watchdog_reset,
	input wire logic core_irq_zero,
	input wire logic core_irq_one,
	input wire logic core_irq_two
);
	import ctic_pkg::*;
	// ==========================================
	// bus answer timing and pulse shapes
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	chk_ready_one_cycle: assert property (pready |=> !pready)
		else $error("answer held too long");
	chk_idle_quiet: assert property (!psel |=> !pready && !pslverr)
		else $error("answer without request");
	chk_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
		else $error("upper read bits set");
	chk_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read not zero");
	// stop flag read: pin, two sync stages, then the setup latch
	chk_stop_flag_live: assert property (pready && !pwrite && !pslverr
		&& paddr == IWW_ADDR |-> prdata[SMR_FLAG_BIT] == $past(stop_recovered_in, 3))
		else $error("stop flag does not follow its pin");
	chk_irq0_single: assert property ($rose(core_irq_zero) |=> !core_irq_zero)
		else $error("input zero pulse too long");
	chk_irq1_single: assert property ($rose(core_irq_one) |=> !core_irq_one)
		else $error("input one pulse too long");
	chk_irq2_single: assert property ($rose(core_irq_two) |=> !core_irq_two)
		else $error("input two pulse too long");
	chk_wdt_single: assert property (watchdog_reset |=> !watchdog_reset)
		else $error("watchdog pulse too long");
endmodule

// file: tb/ctic_pin_model.sv
`timescale 1ns/100ps
module ctic_pin_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cap_level,
	input wire logic hs_go,
	input wire logic vs_go,
	output logic capture_in,
	output logic hsync_in,
	output logic vsync_in
);
	logic [2:0] hs_cnt_ff;
	logic [2:0] vs_cnt_ff;
	// ==========================================
	// sync pins high six cycles per request, low when idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_cnt_ff <= 3'h0;
			vs_cnt_ff <= 3'h0;
		end else begin
			hs_cnt_ff <= hs_go ? 3'h6 : (hs_cnt_ff != 3'h0) ? hs_cnt_ff - 3'h1 : 3'h0;
			vs_cnt_ff <= vs_go ? 3'h6 : (vs_cnt_ff != 3'h0) ? vs_cnt_ff - 3'h1 : 3'h0;
		end
	end
	// capture pin follows the requested level
	assign capture_in = cap_level;
	assign hsync_in = hs_cnt_ff != 3'h0;
	assign vsync_in = vs_cnt_ff != 3'h0;
endmodule

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import ctic_pkg::*;
	localparam logic [1:0] H_DST [8] = '{0, 0, 0, 0, 1, 2, 0, 0};
	localparam logic [1:0] V_DST [8] = '{1, 2, 0, 0, 2, 1, 1, 1};
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'h2794;
	logic pready, pslverr, wake_request, watchdog_reset, capture_in, hsync_in, vsync_in;
	logic core_irq_zero, core_irq_one, core_irq_two, w;
	logic cap_level = 1'b0, hs_go = 1'b0, vs_go = 1'b0, stop_recovered_in = 1'b0;
	logic [5:0] wake_pins = 6'h00;
	logic [7:0] irq_cnt [3] = '{default: 8'h00};
	logic [7:0] wdt_cnt = 8'h00, s2;
	logic [32:0] exp_q [$], msk_q [$], m;
	string nam_q [$];
	int fail_count = 0, comparisons = 0, cycles = 0, k;
	always #20 pclk = ~pclk;
	ctic_timer_irq #(.PER_BASE_CYCLES(20), .WDT0_CYCLES(50), .WDT1_CYCLES(100),
		.WDT2_CYCLES(200), .WDT3_CYCLES(400)) i_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .capture_in, .hsync_in,
		.vsync_in, .stop_recovered_in, .wake_pins, .wake_request, .watchdog_reset,
		.core_irq_zero, .core_irq_one, .core_irq_two);
	ctic_pin_model i_pins (.pclk, .presetn, .cap_level, .hs_go, .vs_go, .capture_in,
		.hsync_in, .vsync_in);
	function automatic logic [31:0] lfsr_step(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic check(input string n, input logic [32:0] e, input logic [32:0] s);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// ==========================================
	// apb master: setup, access until pready, release
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input string n, input logic [7:0] a, input logic [32:0] e,
		input logic [32:0] mk);
		exp_q.push_back(e & mk);
		msk_q.push_back(mk);
		nam_q.push_back(n);
		apb(1'b0, a, 32'h0);
	endtask
	// one sync pulse, then count pulses on each core input
	task automatic fire(input logic vs, input logic [1:0] dst, input logic [2:0] msk);
		logic [7:0] s [3];
		s = irq_cnt;
		if (vs) vs_go <= 1'b1;
		else hs_go <= 1'b1;
		tick(1);
		hs_go <= 1'b0;
		vs_go <= 1'b0;
		tick(15);
		for (int i = 0; i < 3; i++) begin
			check("irq count", {25'h0, s[i] + (i == dst && msk[i])}, {25'h0, irq_cnt[i]});
		end
	endtask
	// ==========================================
	// read monitor and event counters
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
			m = msk_q.pop_front();
			check(nam_q.pop_front(), exp_q.pop_front(), {pslverr, prdata} & m);
		end
		if (core_irq_zero === 1'b1) irq_cnt[0]++;
		if (core_irq_one === 1'b1) irq_cnt[1]++;
		if (core_irq_two === 1'b1) irq_cnt[2]++;
		if (watchdog_reset === 1'b1) wdt_cnt++;
	end
	// hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 30000) begin
			fail_count++;
			summarize();
		end
	end
	initial begin
		tick(10);
		presetn <= 1'b1;
		tick(1);
		rd("timer ctl", TCC_ADDR, 33'h0, 33'h1FFFF);
		rd("irq ctl", IWW_ADDR, 33'h0, 33'h1FFFF);
		rd("unmapped", 8'h40, 33'h100000000, 33'h1FFFFFFFF);
		// every edge code with an 8 cycle filter and a 4 cycle count clock
		for (int e = 0; e < 4; e++) begin
			apb(1'b1, TCC_ADDR, 32'hC004 | (e << 4));
			rd("flags clear", TCC_ADDR, 33'h0, 33'hC000);
			cap_level <= 1'b1;
			tick(4);
			cap_level <= 1'b0;
			tick(20);
			rd("short pulse", TCC_ADDR, 33'h0, 33'hC000);
			cap_level <= 1'b1;
			tick(20);
			cap_level <= 1'b0;
			tick(20);
			rd("edges", TCC_ADDR, {17'h0, e[0], e[1], 14'h0}, 33'hC000);
			apb(1'b1, TCC_ADDR, 32'h0004 | (e << 4));
			rd("write zero", TCC_ADDR, {17'h0, e[0], e[1], 14'h0}, 33'hC000);
		end
		// last pass latched both edges 20 cycles apart: 4 or 5 ticks of 4
		rd("running count", CAPV_ADDR, 33'h4, 33'hFFFE);
		// held count: the second latch must see a frozen zero
		apb(1'b1, TCC_ADDR, 32'hC074);
		cap_level <= 1'b1;
		tick(20);
		cap_level <= 1'b0;
		tick(20);
		rd("held count", CAPV_ADDR, 33'h0, 33'hFFFF);
		// sync routing for all priority codes, capture timer held
		apb(1'b1, TCC_ADDR, 32'h0040);
		for (int p = 0; p < 8; p++) begin
			apb(1'b1, IWW_ADDR, (p << 13) | 32'h1C00);
			fire(1'b0, H_DST[p], 3'h7);
			fire(1'b1, V_DST[p], 3'h7);
		end
		apb(1'b1, IWW_ADDR, 32'h0800);
		fire(1'b0, 2'd0, 3'b010);
		fire(1'b1, 2'd1, 3'b010);
		// periodic timer on input two, codes 11 and 10
		apb(1'b1, IWW_ADDR, 32'h1000);
		for (int c = 3; c > 1; c--) begin
			apb(1'b1, TCC_ADDR, 32'h20C0 | (c << 8));
			s2 = irq_cnt[2];
			tick(80 << (2 * (3 - c)));
			k = irq_cnt[2] - s2;
			check("periodic rate", 33'h1, {32'h0, k >= 3 && k <= 5});
			rd("periodic flag", TCC_ADDR, 33'h2000, 33'h2000);
		end
		// wake combine with random pins and enables
		repeat (4) begin
			lfsr = lfsr_step(lfsr);
			apb(1'b1, IWW_ADDR, {24'h0, 1'b1, lfsr[12], lfsr[5:0]});
			wake_pins <= lfsr[11:6];
			rd("irq ctl", IWW_ADDR, {25'h0, 1'b0, lfsr[12], lfsr[5:0]}, 33'h1FFFF);
			tick(6);
			w = lfsr[5:0] == 6'h0 ? 1'b0 :
				lfsr[12] ? ~&(lfsr[11:6] | ~lfsr[5:0]) : |(lfsr[11:6] & lfsr[5:0]);
			check("wake", {32'h0, w}, {32'h0, wake_request});
		end
		stop_recovered_in <= 1'b1;
		tick(4);
		rd("stop flag", IWW_ADDR, 33'h80, 33'h80);
		// watchdog idle since reset, then shortest period
		check("wdt idle", 33'h0, {25'h0, wdt_cnt});
		apb(1'b1, IWW_ADDR, 32'h0);
		apb(1'b1, WDC_ADDR, 32'h1);
		s2 = wdt_cnt;
		k = 0;
		while (wdt_cnt === s2 && k < 100) begin
			tick(1);
			k++;
		end
		check("wdt time", 33'h1, {32'h0, k >= 44 && k <= 52});
		// slow mode refuses a start; a reset in mid-run stops the watchdog
		apb(1'b1, WDC_ADDR, 32'h3);
		rd("wdt slow", WDC_ADDR, 33'h2, 33'h3);
		apb(1'b1, WDC_ADDR, 32'h1);
		tick(5);
		presetn <= 1'b0;
		tick(2);
		presetn <= 1'b1;
		tick(2);
		s2 = wdt_cnt;
		rd("wdt ctl", WDC_ADDR, 33'h0, 33'h3);
		tick(60);
		check("wdt after reset", 33'h0, {25'h0, wdt_cnt - s2});
		summarize();
	end
endmodule
bind ctic_timer_irq ctic_timer_irq_checker i_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .stop_recovered_in, .watchdog_reset,
	.core_irq_zero, .core_irq_one, .core_irq_two);
